// >>> include/fss_regs.svh
// Register offsets, field positions, reset values and timing figures of the fault sequencer
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH
`define FSS_CTRL_OFS 8'h00
`define FSS_CMD_OFS 8'h04
`define FSS_STAT_OFS 8'h08
`define FSS_PRE_OFS 8'h0c
`define FSS_FLT_OFS 8'h10
`define FSS_POST_OFS 8'h14
`define FSS_NOM_OFS 8'h18
`define FSS_FREQ_OFS 8'h1c
`define FSS_QUANT_IDX0 6'h10
`define FSS_QUANT_N 36
`define FSS_QUANT_PER_PH 12
`define FSS_CTRL_TRIP_BIT 0
`define FSS_CTRL_JUMP_BIT 1
`define FSS_CTRL_TRIG_BIT 2
`define FSS_CMD_LAUNCH_BIT 0
`define FSS_CMD_ABORT_BIT 1
`define FSS_CODE_NORMAL 3'h0
`define FSS_CODE_PRE 3'h1
`define FSS_CODE_FAULT 3'h2
`define FSS_CODE_POST 3'h3
`define FSS_CODE_RESET 3'h4
`define FSS_DUR_RST 16'h03e8
`define FSS_NOM_RST 16'h03e8
`define FSS_FREQ_RST 16'hc350
`define FSS_CLK_HZ 125000000
`define FSS_MS_PER_S 1000
`define FSS_RESET_STAGE_MS 100
`define FSS_OC_HOLD_S 5
`define FSS_OC_RATIO_DIV 20'h0000a
`define FSS_FREQ_MUL 32'h00002720
`define FSS_FREQ_DIV 32'h00002710
`endif

// >>> include/fss_pkg.sv
// Types shared by the fault sequencer
package fss_pkg;
    typedef enum logic [2:0] {
        FSS_IDLE, FSS_RST_IN, FSS_PRE, FSS_FLT, FSS_POST, FSS_RST_OUT
    } fss_state_e;
    typedef logic [15:0] fss_word_t;
    typedef struct packed {
        fss_state_e state;
        logic [31:0] ms_div;
        logic [15:0] cnt;
        logic [15:0] oc_cnt;
        logic oc_lock;
        logic trig_q;
        logic jump_q;
        logic trip_permit;
        logic jump_en;
        logic trig_en;
        fss_word_t pre_dur;
        fss_word_t flt_dur;
        fss_word_t post_dur;
        fss_word_t nom_cur;
        fss_word_t rated_freq;
        logic [35:0][15:0] quant;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [2:0] state_code;
        logic prot_reinit;
        logic energy_freeze;
        logic trip_command;
        logic sim_active;
        logic volt_ph_n;
        logic [11:0][15:0] sim_values;
        logic [16:0] sim_freq;
    } fss_state_s;
endpackage : fss_pkg

// >>> rtl/fss_top.sv
// Fault simulation sequencer with APB register file
`timescale 1ns/100ps
`include "fss_regs.svh"
module fss_top
    import fss_pkg::*;
#(
    parameter int MS_CYCLES = `FSS_CLK_HZ / `FSS_MS_PER_S,
    parameter int RESET_MS = `FSS_RESET_STAGE_MS,
    parameter int OC_HOLD_MS = `FSS_OC_HOLD_S * `FSS_MS_PER_S
) (
    input wire logic pclk, // Clock, 125 MHz
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [15:0] phase_cur_a, // Measured current, conductor a
    input wire logic [15:0] phase_cur_b, // Measured current, conductor b
    input wire logic [15:0] phase_cur_c, // Measured current, conductor c
    input wire logic ext_block_a, // Blocking input a
    input wire logic ext_block_b, // Blocking input b
    input wire logic ext_jump_to_post, // Force post-fault
    input wire logic ext_sim_trigger, // External start
    input wire logic prot_trip_req, // Trip decision of protection
    output logic [2:0] state_code, // Recorder state code
    output logic prot_reinit, // Protection held in reset
    output logic energy_freeze, // Stop energy counters
    output logic trip_command, // Gated trip to breaker
    output logic sim_active, // Substitute simulated quantities
    output logic volt_ph_n, // Voltages are phase-to-neutral
    output logic [191:0] sim_values, // Quantities of active phase
    output logic [16:0] sim_freq // Simulated frequency, mHz
);
    fss_state_s r;
    fss_state_s n;
    logic overcurrent;
    logic blocked;
    logic tick;
    logic launch_w;
    logic abort_w;
    logic trig_edge;
    logic jump_edge;
    logic phase_done;
    logic wr_acc;
    logic [15:0] cur_dur;
    logic [5:0] widx;
    logic [5:0] qidx;
    logic [19:0] thr;

    // ------------------------------------------------------------
    // Qualifiers
    // ------------------------------------------------------------
    // Compare 10*I against In to avoid a divider on the threshold
    assign thr = {4'h0, r.nom_cur};
    assign overcurrent = (20'(phase_cur_a) * `FSS_OC_RATIO_DIV > thr)
        || (20'(phase_cur_b) * `FSS_OC_RATIO_DIV > thr)
        || (20'(phase_cur_c) * `FSS_OC_RATIO_DIV > thr);
    assign blocked = ext_block_a || ext_block_b;
    assign tick = (r.ms_div == 32'(MS_CYCLES - 1));
    assign wr_acc = psel && penable && r.pready && pwrite;
    assign widx = paddr[7:2];
    assign qidx = widx - `FSS_QUANT_IDX0;
    assign launch_w = wr_acc && (paddr == `FSS_CMD_OFS) && pwdata[`FSS_CMD_LAUNCH_BIT];
    assign abort_w = wr_acc && (paddr == `FSS_CMD_OFS) && pwdata[`FSS_CMD_ABORT_BIT];
    assign trig_edge = ext_sim_trigger && !r.trig_q && r.trig_en;
    assign jump_edge = ext_jump_to_post && !r.jump_q && r.jump_en;

    always_comb begin
        case (r.state)
            FSS_RST_IN, FSS_RST_OUT: cur_dur = 16'(RESET_MS);
            FSS_PRE: cur_dur = r.pre_dur;
            FSS_FLT: cur_dur = r.flt_dur;
            FSS_POST: cur_dur = r.post_dur;
            default: cur_dur = 16'h0000;
        endcase
    end
    assign phase_done = tick && (r.cnt + 16'h0001 >= cur_dur);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic quant_hit;
        logic [29:0] fprod;
        quant_hit = (widx >= `FSS_QUANT_IDX0) && (qidx < 6'(`FSS_QUANT_N));
        fprod = 30'h0;
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.trig_q = ext_sim_trigger;
        n.jump_q = ext_jump_to_post;
        n.ms_div = tick ? 32'h0 : r.ms_div + 32'h1;
        // Register reads answer one cycle after setup
        if (psel && !penable) begin
            n.pready = 1'b1;
            n.prdata = 32'h0;
            case (paddr)
                `FSS_CTRL_OFS: n.prdata = {29'h0, r.trig_en, r.jump_en, r.trip_permit};
                `FSS_CMD_OFS: n.prdata = 32'h0;
                `FSS_STAT_OFS: n.prdata = {26'h0, blocked, overcurrent, r.oc_lock, r.state_code};
                `FSS_PRE_OFS: n.prdata = {16'h0, r.pre_dur};
                `FSS_FLT_OFS: n.prdata = {16'h0, r.flt_dur};
                `FSS_POST_OFS: n.prdata = {16'h0, r.post_dur};
                `FSS_NOM_OFS: n.prdata = {16'h0, r.nom_cur};
                `FSS_FREQ_OFS: n.prdata = {16'h0, r.rated_freq};
                default: begin
                    if (quant_hit) begin
                        n.prdata = {16'h0, r.quant[qidx]};
                    end else begin
                        n.pslverr = 1'b1;
                    end
                end
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                `FSS_CTRL_OFS: begin
                    n.trip_permit = pwdata[`FSS_CTRL_TRIP_BIT];
                    n.jump_en = pwdata[`FSS_CTRL_JUMP_BIT];
                    n.trig_en = pwdata[`FSS_CTRL_TRIG_BIT];
                end
                `FSS_PRE_OFS: n.pre_dur = pwdata[15:0];
                `FSS_FLT_OFS: n.flt_dur = pwdata[15:0];
                `FSS_POST_OFS: n.post_dur = pwdata[15:0];
                `FSS_NOM_OFS: n.nom_cur = pwdata[15:0];
                `FSS_FREQ_OFS: n.rated_freq = pwdata[15:0];
                default: begin
                    if (quant_hit) begin
                        n.quant[qidx] = pwdata[15:0];
                    end
                end
            endcase
        end
        if (tick) begin
            n.cnt = r.cnt + 16'h0001;
        end
        // Sequencer; jump is only looked at in pre-fault and fault
        case (r.state)
            FSS_IDLE: begin
                n.cnt = 16'h0000;
                if ((launch_w || trig_edge) && !blocked && !overcurrent && !r.oc_lock) begin
                    n.state = FSS_RST_IN;
                end
            end
            FSS_RST_IN: begin
                if (phase_done) begin
                    n.state = FSS_PRE;
                    n.cnt = 16'h0000;
                end
            end
            FSS_PRE: begin
                if (jump_edge) begin
                    n.state = FSS_POST;
                    n.cnt = 16'h0000;
                end else if (phase_done) begin
                    n.state = FSS_FLT;
                    n.cnt = 16'h0000;
                end
            end
            FSS_FLT: begin
                if (jump_edge || phase_done) begin
                    n.state = FSS_POST;
                    n.cnt = 16'h0000;
                end
            end
            FSS_POST: begin
                if (phase_done) begin
                    n.state = FSS_RST_OUT;
                    n.cnt = 16'h0000;
                end
            end
            FSS_RST_OUT: begin
                if (phase_done) begin
                    n.state = FSS_IDLE;
                    n.cnt = 16'h0000;
                end
            end
            default: n.state = FSS_IDLE;
        endcase
        // Aborts override any timed step outside the closing reset stage
        if ((abort_w || overcurrent) && (r.state != FSS_IDLE) && (r.state != FSS_RST_OUT)) begin
            n.state = FSS_RST_OUT;
            n.cnt = 16'h0000;
        end
        // Lockout restarts its count on any overcurrent sample
        if (overcurrent) begin
            n.oc_cnt = 16'h0000;
            if (r.state != FSS_IDLE) begin
                n.oc_lock = 1'b1;
            end
        end else if (r.oc_lock && tick) begin
            n.oc_cnt = r.oc_cnt + 16'h0001;
            if (r.oc_cnt + 16'h0001 >= 16'(OC_HOLD_MS)) begin
                n.oc_lock = 1'b0;
            end
        end
        // Outputs follow the next state so they line up with it
        case (n.state)
            FSS_PRE: n.state_code = `FSS_CODE_PRE;
            FSS_FLT: n.state_code = `FSS_CODE_FAULT;
            FSS_POST: n.state_code = `FSS_CODE_POST;
            FSS_RST_IN, FSS_RST_OUT: n.state_code = `FSS_CODE_RESET;
            default: n.state_code = `FSS_CODE_NORMAL;
        endcase
        n.prot_reinit = (n.state == FSS_RST_IN) || (n.state == FSS_RST_OUT);
        n.energy_freeze = (n.state != FSS_IDLE);
        n.sim_active = (n.state != FSS_IDLE);
        n.volt_ph_n = 1'b1;
        n.trip_command = prot_trip_req && ((n.state == FSS_IDLE)
            || (r.trip_permit && !n.prot_reinit));
        n.sim_values = '0;
        for (int p = 0; p < 3; p++) begin
            if (n.state == fss_state_e'(int'(FSS_PRE) + p)) begin
                n.sim_values = r.quant[p*`FSS_QUANT_PER_PH +: `FSS_QUANT_PER_PH];
            end
        end
        // Truncating divide; error below one mHz
        fprod = 30'(32'(r.rated_freq) * `FSS_FREQ_MUL / `FSS_FREQ_DIV);
        n.sim_freq = fprod[16:0];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.state <= FSS_IDLE;
            r.pre_dur <= `FSS_DUR_RST;
            r.flt_dur <= `FSS_DUR_RST;
            r.post_dur <= `FSS_DUR_RST;
            r.nom_cur <= `FSS_NOM_RST;
            r.rated_freq <= `FSS_FREQ_RST;
            r.volt_ph_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign state_code = r.state_code;
    assign prot_reinit = r.prot_reinit;
    assign energy_freeze = r.energy_freeze;
    assign trip_command = r.trip_command;
    assign sim_active = r.sim_active;
    assign volt_ph_n = r.volt_ph_n;
    assign sim_values = r.sim_values;
    assign sim_freq = r.sim_freq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_fault_after_pre;
        $changed(state_code) && state_code == `FSS_CODE_FAULT |-> $past(state_code) == `FSS_CODE_PRE;
    endproperty
    a_fault_after_pre: assert property (p_fault_after_pre) else $error("fault not entered from pre-fault");

    property p_reinit_code;
        prot_reinit == (state_code == `FSS_CODE_RESET);
    endproperty
    a_reinit_code: assert property (p_reinit_code) else $error("reinit and code 4 disagree");

    property p_oc_abort;
        overcurrent && state_code inside {3'h1, 3'h2, 3'h3} |=> state_code == `FSS_CODE_RESET && r.oc_lock;
    endproperty
    a_oc_abort: assert property (p_oc_abort) else $error("overcurrent did not abort");

    property p_lock_refuse;
        r.oc_lock && state_code == `FSS_CODE_NORMAL |=> state_code == `FSS_CODE_NORMAL;
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("start during overcurrent lockout");

    property p_block;
        blocked && state_code == `FSS_CODE_NORMAL |=> state_code == `FSS_CODE_NORMAL;
    endproperty
    a_block: assert property (p_block) else $error("start while blocked");

    property p_jump;
        jump_edge && !abort_w && !overcurrent && state_code inside {3'h1, 3'h2} |=> state_code == `FSS_CODE_POST;
    endproperty
    a_jump: assert property (p_jump) else $error("jump did not reach post-fault");

    property p_freeze;
        energy_freeze == (state_code != `FSS_CODE_NORMAL);
    endproperty
    a_freeze: assert property (p_freeze) else $error("energy freeze wrong");

    property p_trip_block;
        !$past(r.trip_permit) && state_code inside {3'h1, 3'h2, 3'h3} |-> !trip_command;
    endproperty
    a_trip_block: assert property (p_trip_block) else $error("trip not suppressed");

    property p_abort;
        abort_w && state_code inside {3'h1, 3'h2, 3'h3} |=> state_code == `FSS_CODE_RESET;
    endproperty
    a_abort: assert property (p_abort) else $error("manual abort ignored");

    property p_idle_via_reset;
        $changed(state_code) && state_code == `FSS_CODE_NORMAL |-> $past(state_code) == `FSS_CODE_RESET;
    endproperty
    a_idle_via_reset: assert property (p_idle_via_reset) else $error("normal reached without reset stage");

    c_post: cover property (state_code == `FSS_CODE_POST);
    c_oc_abort: cover property (overcurrent && state_code == `FSS_CODE_FAULT ##1 state_code == `FSS_CODE_RESET);
    c_jump: cover property (jump_edge && state_code == `FSS_CODE_FAULT ##1 state_code == `FSS_CODE_POST);
endmodule : fss_top

// >>> verification/fss_field_model.sv
// Far-side model: current sensors and one protection function
`timescale 1ns/100ps
module fss_field_model (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic [2:0] state_code, // Sequencer code
    input wire logic [15:0] cur_level, // Current presented on conductor b
    output logic [15:0] phase_cur_a, // Conductor a
    output logic [15:0] phase_cur_b, // Conductor b
    output logic [15:0] phase_cur_c, // Conductor c
    output logic prot_trip_req, // Trip decision
    output logic ext_jump_to_post // Trip decision wired to force post
);
    logic [1:0] dly_reg;
    // Protection needs two cycles of fault before it decides
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_reg <= 2'h0;
        end else begin
            dly_reg <= (state_code == 3'h2) ? {dly_reg[0], 1'b1} : 2'h0;
        end
    end
    assign prot_trip_req = dly_reg[1];
    assign ext_jump_to_post = dly_reg[1];
    assign phase_cur_a = 16'h0000;
    assign phase_cur_b = cur_level;
    assign phase_cur_c = 16'h0000;
endmodule : fss_field_model

// >>> verification/fss_top_test.sv
// Self-checking bench of the fault sequencer
`timescale 1ns/100ps
module fss_top_test;
    localparam int MSC = 4;
    localparam int RMS = 3;
    localparam int OCH = 5;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} fss_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, ext_jump_to_post, prot_trip_req;
    logic [15:0] cur_a, cur_b, cur_c, cur_level = 16'h0000;
    logic ext_block_a = 1'b0, ext_block_b = 1'b0, ext_sim_trigger = 1'b0;
    logic [2:0] state_code;
    logic prot_reinit, energy_freeze, trip_command, sim_active, volt_ph_n;
    logic [191:0] sim_values;
    logic [16:0] sim_freq;
    logic trip_seen = 1'b0;
    int failures = 0;
    int check_count = 0;
    int n;
    fss_row_s rows [0:20] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h0c, 32'h0, 32'h3e8, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h3e8, 1'b0},
        '{1'b0, 8'h14, 32'h0, 32'h3e8, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h3e8, 1'b0},
        '{1'b0, 8'h1c, 32'h0, 32'hc350, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h20, 32'h5, 32'h0, 1'b1},
        '{1'b1, 8'h0c, 32'hffff0002, 32'h0, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h2, 1'b0},
        '{1'b1, 8'h10, 32'h3, 32'h0, 1'b0}, '{1'b1, 8'h14, 32'h2, 32'h0, 1'b0},
        '{1'b1, 8'h40, 32'h1111, 32'h0, 1'b0}, '{1'b0, 8'h40, 32'h0, 32'h1111, 1'b0},
        '{1'b1, 8'h70, 32'h2222, 32'h0, 1'b0}, '{1'b1, 8'ha0, 32'h3333, 32'h0, 1'b0},
        '{1'b1, 8'h1c, 32'hea60, 32'h0, 1'b0}, '{1'b0, 8'h1c, 32'h0, 32'hea60, 1'b0},
        '{1'b0, 8'hd0, 32'h0, 32'h0, 1'b1}};

    always #4 pclk = ~pclk;
    always @(posedge pclk) if (trip_command === 1'b1) trip_seen <= 1'b1;

    fss_top #(.MS_CYCLES(MSC), .RESET_MS(RMS), .OC_HOLD_MS(OCH)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_cur_a(cur_a), .phase_cur_b(cur_b), .phase_cur_c(cur_c),
        .ext_block_a(ext_block_a), .ext_block_b(ext_block_b), .ext_jump_to_post(ext_jump_to_post),
        .ext_sim_trigger(ext_sim_trigger), .prot_trip_req(prot_trip_req), .state_code(state_code),
        .prot_reinit(prot_reinit), .energy_freeze(energy_freeze), .trip_command(trip_command),
        .sim_active(sim_active), .volt_ph_n(volt_ph_n), .sim_values(sim_values), .sim_freq(sim_freq));
    fss_field_model field (
        .pclk(pclk), .presetn(presetn), .state_code(state_code), .cur_level(cur_level),
        .phase_cur_a(cur_a), .phase_cur_b(cur_b), .phase_cur_c(cur_c),
        .prot_trip_req(prot_trip_req), .ext_jump_to_post(ext_jump_to_post));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) failures++;
    endtask : apb

    task automatic launch(input logic [31:0] cmd);
        apb(1'b1, 8'h04, cmd);
        #1;
    endtask : launch

    // Waits for a code; the span of the state left must fit its duration
    task automatic wait_ms(input logic [2:0] c, input int d);
        n = 0;
        while (state_code !== c && n < d * MSC + 6) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check("state_code", state_code, c);
        check("phase span", (n >= (d - 1) * MSC && n <= d * MSC + 2), 1);
    endtask : wait_ms

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        #300000;
        failures++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        check("volt_ph_n in reset", volt_ph_n, 1);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        check("state_code", state_code, 0);
        check("energy_freeze", energy_freeze, 0);
        check("sim_freq", sim_freq, 32'hc3a0);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) check("prdata", rd, rows[i].exp);
            check("pslverr", er, rows[i].err);
        end
        @(posedge pclk);
        #1;
        check("sim_freq", sim_freq, 32'heac0);
        // Cold run: protection trips in fault, breaker must not see it
        trip_seen = 1'b0;
        launch(32'h1);
        check("state_code", state_code, 4);
        check("prot_reinit", prot_reinit, 1);
        check("energy_freeze", energy_freeze, 1);
        check("sim_active", sim_active, 1);
        wait_ms(3'h1, RMS);
        check("prot_reinit", prot_reinit, 0);
        check("pre word", sim_values[15:0], 32'h1111);
        check("volt_ph_n", volt_ph_n, 1);
        wait_ms(3'h2, 2);
        check("fault word", sim_values[15:0], 32'h2222);
        wait_ms(3'h3, 3);
        check("post word", sim_values[15:0], 32'h3333);
        wait_ms(3'h4, 2);
        check("prot_reinit", prot_reinit, 1);
        wait_ms(3'h0, RMS);
        check("energy_freeze", energy_freeze, 0);
        check("sim_values", sim_values[31:0], 0);
        check("trip_seen", trip_seen, 0);
        // Hot run: the trip decision forces post-fault early
        apb(1'b1, 8'h00, 32'h3);
        trip_seen = 1'b0;
        launch(32'h1);
        wait_ms(3'h1, RMS);
        wait_ms(3'h2, 2);
        wait_ms(3'h3, 1);
        wait_ms(3'h4, 2);
        wait_ms(3'h0, RMS);
        check("trip_seen", trip_seen, 1);
        // Manual abort in pre-fault
        launch(32'h1);
        wait_ms(3'h1, RMS);
        launch(32'h2);
        check("state_code", state_code, 4);
        wait_ms(3'h0, RMS);
        // Overcurrent just above and exactly at the threshold
        @(posedge pclk);
        cur_level <= 16'h0065;
        launch(32'h1);
        check("state_code", state_code, 0);
        @(posedge pclk);
        cur_level <= 16'h0064;
        launch(32'h1);
        check("state_code", state_code, 4);
        wait_ms(3'h1, RMS);
        @(posedge pclk);
        cur_level <= 16'h00c8;
        wait_ms(3'h4, 1);
        @(posedge pclk);
        cur_level <= 16'h0000;
        wait_ms(3'h0, RMS);
        launch(32'h1);
        check("state_code", state_code, 0);
        repeat (OCH * MSC) @(posedge pclk);
        launch(32'h1);
        check("state_code", state_code, 4);
        launch(32'h2);
        wait_ms(3'h0, RMS);
        // Blocking inputs against manual and external start
        apb(1'b1, 8'h00, 32'h4);
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            ext_block_a <= (i == 0);
            ext_block_b <= (i == 1);
            launch(32'h1);
            check("state_code", state_code, 0);
            @(posedge pclk);
            ext_sim_trigger <= 1'b1;
            repeat (3) @(posedge pclk);
            #1;
            check("state_code", state_code, 0);
            @(posedge pclk);
            ext_sim_trigger <= 1'b0;
            ext_block_a <= 1'b0;
            ext_block_b <= 1'b0;
        end
        @(posedge pclk);
        ext_sim_trigger <= 1'b1;
        wait_ms(3'h4, 1);
        launch(32'h2);
        wait_ms(3'h0, RMS);
        finish_test();
    end
endmodule : fss_top_test
